// File: hdl/c8dec_defs.vh
/*
  Constants for the instruction decoder: register offsets, field positions,
  reset values and opcode group codes.
  Assumes inclusion by bare name from the decoder design file.
*/
`ifndef C8DEC_DEFS_VH
`define C8DEC_DEFS_VH

`define C8DEC_ADR_OPCODE   8'h00
`define C8DEC_ADR_OPERAND  8'h04
`define C8DEC_ADR_STATE    8'h08
`define C8DEC_ADR_PC       8'h0C
`define C8DEC_ADR_DECODE   8'h10
`define C8DEC_ADR_EA       8'h14
`define C8DEC_ADR_NEXTPC   8'h18
`define C8DEC_ADR_RESULT   8'h1C

`define C8DEC_RST_OPCODE   8'h9D
`define C8DEC_RST_BYTE     8'h00
`define C8DEC_RST_CC       5'h08
`define C8DEC_RST_PC       16'h0000

`define C8DEC_CC_H         4
`define C8DEC_CC_I         3
`define C8DEC_CC_N         2
`define C8DEC_CC_Z         1
`define C8DEC_CC_C         0

`define C8DEC_HI_IMM       4'hA
`define C8DEC_HI_DIR       4'hB
`define C8DEC_HI_EXT       4'hC
`define C8DEC_HI_IX2       4'hD
`define C8DEC_HI_IX1       4'hE
`define C8DEC_HI_IX0       4'hF
`define C8DEC_HI_RMW_DIR   4'h3
`define C8DEC_HI_RMW_ACC   4'h4
`define C8DEC_HI_RMW_IDX   4'h5
`define C8DEC_HI_RMW_IX1   4'h6
`define C8DEC_HI_RMW_IX0   4'h7

`define C8DEC_LO_TEST      4'hD
`define C8DEC_LO_ZERO      4'hF
`define C8DEC_LO_LDACC     4'h6
`define C8DEC_LO_LDIDX     4'hE
`define C8DEC_LO_STACC     4'h7
`define C8DEC_LO_STIDX     4'hF
`define C8DEC_LO_JUMP      4'hC
`define C8DEC_LO_CALL      4'hD
`define C8DEC_LO_ADD       4'hB
`define C8DEC_LO_ADC       4'h9

`define C8DEC_SP_RESET     8'hFF

`endif

// File: hdl/c8dec_top.v
/*
  Instruction decoder for an 8-bit microcomputer core, exposed as a classic
  Wishbone slave. Software loads an opcode, its operand bytes, the memory
  byte it reaches, the core registers and flags, and reads back length,
  cycle count, effective address, next program counter and flag effects.
  Assumes one 250 MHz clock, a synchronous active-high reset, and an
  interrupt pin that arrives asynchronously.
*/
// Design decisions made here: the Wishbone slave port and the register addresses.
// Notes on behaviour
// RULE1 - Sixteen-bit offset indexed: address is two operand bytes plus index, three bytes.
// RULE2 - Page-zero bit set/clear: bit from opcode bits three to one, address from byte two.
// RULE3 - Bit test jump: three bytes, byte two address, byte three displacement.
// RULE4 - Bit test jump copies the tested bit into carry, taken or not.
// RULE5 - Implied instructions are one byte with no effective address.
// RULE6 - Zero/sign test reads and tests but never writes back.
// RULE7 - Register/memory mode sits in high nibble, operation in low nibble.
// RULE8 - Loads and arithmetic take 2,3,4,3,4,5 cycles across the modes.
// RULE9 - Stores have no immediate form and take 3,4,4,4,5 cycles.
// RULE10 - Jump takes 2,3,2,3,4 cycles; call takes 5,6,5,5,6 cycles.
// RULE11 - Read-modify-write nibbles 4,5,3,7,6 take 2,2,5,5,6 cycles.
// RULE12 - Zero/sign test takes 2,2,4,4,5 cycles.
// RULE13 - Zero fill writes 00, clears N, sets Z, keeps H, I, C.
// RULE14 - Relative branches 20-2F are two bytes, three cycles; relative call five.
// RULE15 - Branch conditions follow the low nibble, last two test the interrupt pin.
// RULE16 - Bit jump opcodes 2n/2n+1 take five cycles; bit set/clear also five.
// RULE17 - Transfers two cycles, carry set/clear one, mask set/clear two cycles.
// RULE18 - Trap ten cycles sets mask; return five; trap return eight restores flags.
// RULE19 - Stack reset loads FF in two cycles; no-operation one cycle.
// RULE20 - Decimal adjust corrects BCD, updates N and Z, carry is sticky.
// RULE21 - Halt and sleep opcodes are one byte, four cycles, flags kept.
// RULE22 - Branch target is instruction address plus two plus signed displacement.
// RULE23 - Half carry comes from the carry out of bit three of an addition.
// RULE24 - Undefined opcodes decode as a one-byte, one-cycle no-operation.
`include "c8dec_defs.vh"

module c8dec_top (
  // Clock and reset
  input  wire        clk_i,
  input  wire        rst_i,
  // Wishbone slave
  input  wire [7:0]  wb_adr_i,
  input  wire [31:0] wb_dat_i,
  input  wire [3:0]  wb_sel_i,
  input  wire        wb_we_i,
  input  wire        wb_cyc_i,
  input  wire        wb_stb_i,
  output reg  [31:0] wb_dat_o,
  output reg         wb_ack_o,
  // Interrupt pin level
  input  wire        irq_pin_i
);

  reg  [7:0]  opcode;
  reg  [7:0]  byte1;
  reg  [7:0]  byte2;
  reg  [7:0]  mem_data;
  reg  [7:0]  acc;
  reg  [7:0]  idx;
  reg  [4:0]  ccr;
  reg  [15:0] pc;
  reg         irq_meta;
  reg         irq_sync;

  reg  [31:0] snap_decode;
  reg  [15:0] snap_ea;
  reg  [15:0] snap_npc;
  reg  [31:0] snap_result;

  reg  [1:0]  d_len;
  reg  [3:0]  d_cyc;
  reg         d_def;
  reg         d_has_ea;
  reg         d_wr;
  reg         d_take;
  reg         d_jump;
  reg  [15:0] d_ea;
  reg  [15:0] d_tgt;
  reg  [15:0] d_npc;
  reg  [7:0]  d_res;
  reg         d_resv;
  reg  [4:0]  d_cc;
  reg  [8:0]  sum;
  reg  [4:0]  half;
  reg         bitv;
  reg  [7:0]  mask;
  reg  [8:0]  daa_v;
  reg  [31:0] next_dat;

  wire [3:0]  hi = opcode[7:4];
  wire [3:0]  lo = opcode[3:0];
  wire        bus_go = wb_cyc_i & wb_stb_i & ~wb_ack_o;

  function [7:0] merge8;
    input [7:0] old;
    input [7:0] nw;
    input       en;
    begin
      merge8 = en ? nw : old;
    end
  endfunction

  function [15:0] sext;
    input [7:0] b;
    begin
      sext = {{8{b[7]}}, b};
    end
  endfunction

  // Cycle counts of register/memory instructions: class 0 load/alu,
  // 1 store, 2 jump, 3 call.
  function [3:0] rm_cycles;
    input [3:0] mode;
    input [1:0] cls;
    begin
      rm_cycles = 4'h1;
      case (mode)
        `C8DEC_HI_IMM: rm_cycles = 4'h2;
        `C8DEC_HI_DIR: rm_cycles = (cls == 2'd2) ? 4'h2 : (cls == 2'd3) ? 4'h5 : 4'h3;
        `C8DEC_HI_EXT: rm_cycles = (cls == 2'd2) ? 4'h3 : (cls == 2'd3) ? 4'h6 : 4'h4;
        `C8DEC_HI_IX0: rm_cycles = (cls == 2'd2) ? 4'h2 : (cls == 2'd3) ? 4'h5 :
                                   (cls == 2'd1) ? 4'h4 : 4'h3;
        `C8DEC_HI_IX1: rm_cycles = (cls == 2'd2) ? 4'h3 : (cls == 2'd3) ? 4'h5 : 4'h4;
        `C8DEC_HI_IX2: rm_cycles = (cls == 2'd2) ? 4'h4 : (cls == 2'd3) ? 4'h6 : 4'h5;
        default:       rm_cycles = 4'h1;
      endcase
    end
  endfunction

  function brn_cond;
    input [3:0] sel;
    input [4:0] cc;
    input       irq;
    begin
      case (sel[3:1])
        3'd0:    brn_cond = 1'b1;
        3'd1:    brn_cond = ~(cc[`C8DEC_CC_C] | cc[`C8DEC_CC_Z]);
        3'd2:    brn_cond = ~cc[`C8DEC_CC_C];
        3'd3:    brn_cond = ~cc[`C8DEC_CC_Z];
        3'd4:    brn_cond = ~cc[`C8DEC_CC_H];
        3'd5:    brn_cond = ~cc[`C8DEC_CC_N];
        3'd6:    brn_cond = ~cc[`C8DEC_CC_I];
        default: brn_cond = ~irq;
      endcase
      brn_cond = brn_cond ^ sel[0];
    end
  endfunction

  function rmw_defined;
    input [3:0] op;
    begin
      case (op)
        4'h1, 4'h2, 4'h5, 4'hB, 4'hE: rmw_defined = 1'b0;
        default:                      rmw_defined = 1'b1;
      endcase
    end
  endfunction

  // Flags N and Z from a byte result.
  function [4:0] nz;
    input [4:0] cc;
    input [7:0] v;
    begin
      nz = cc;
      nz[`C8DEC_CC_N] = v[7];
      nz[`C8DEC_CC_Z] = (v == 8'h00);
    end
  endfunction

  always @* begin
    d_len    = 2'd1;
    d_cyc    = 4'h1;
    d_def    = 1'b1;
    d_has_ea = 1'b0;
    d_wr     = 1'b0;
    d_take   = 1'b0;
    d_jump   = 1'b0;
    d_ea     = 16'h0000;
    d_tgt    = 16'h0000;
    d_res    = 8'h00;
    d_resv   = 1'b0;
    d_cc     = ccr;
    mask     = 8'h01 << opcode[3:1];
    bitv     = |(mem_data & mask);
    half     = {1'b0, acc[3:0]} + {1'b0, mem_data[3:0]} +
               {4'h0, ccr[`C8DEC_CC_C] & (lo == `C8DEC_LO_ADC)};
    sum      = {1'b0, acc} + {1'b0, mem_data} +
               {8'h00, ccr[`C8DEC_CC_C] & (lo == `C8DEC_LO_ADC)};
    daa_v    = {1'b0, acc};
    if (ccr[`C8DEC_CC_H] || acc[3:0] > 4'h9) begin
      daa_v = daa_v + 9'h006;
    end
    if (ccr[`C8DEC_CC_C] || acc[7:4] > 4'h9 || (acc[7:4] > 4'h8 && acc[3:0] > 4'h9)) begin
      daa_v = daa_v + 9'h060;
      daa_v[8] = 1'b1;
    end
    case (hi)
      4'h0: begin
        d_len    = 2'd3; // RULE3
        d_cyc    = 4'h5; // RULE16
        d_has_ea = 1'b1;
        d_ea     = {8'h00, byte1}; // RULE3
        d_cc[`C8DEC_CC_C] = bitv; // RULE4
        d_take   = opcode[0] ? ~bitv : bitv; // RULE16
        d_jump   = d_take;
        d_tgt    = pc + 16'h0003 + sext(byte2); // RULE3
      end
      4'h1: begin
        d_len    = 2'd2;
        d_cyc    = 4'h5; // RULE16
        d_has_ea = 1'b1;
        d_ea     = {8'h00, byte1}; // RULE2
        d_wr     = 1'b1;
        d_res    = opcode[0] ? (mem_data & ~mask) : (mem_data | mask); // RULE2
        d_resv   = 1'b1;
      end
      4'h2: begin
        d_len  = 2'd2; // RULE14
        d_cyc  = 4'h3; // RULE14
        d_take = brn_cond(lo, ccr, irq_sync); // RULE15
        d_jump = d_take;
        d_tgt  = pc + 16'h0002 + sext(byte1); // RULE22
      end
      `C8DEC_HI_RMW_DIR, `C8DEC_HI_RMW_ACC, `C8DEC_HI_RMW_IDX,
      `C8DEC_HI_RMW_IX1, `C8DEC_HI_RMW_IX0: begin
        d_def = rmw_defined(lo);
        if (d_def) begin
          d_has_ea = (hi == `C8DEC_HI_RMW_DIR) || (hi == `C8DEC_HI_RMW_IX1) ||
                     (hi == `C8DEC_HI_RMW_IX0);
          d_len    = (hi == `C8DEC_HI_RMW_DIR || hi == `C8DEC_HI_RMW_IX1) ? 2'd2 : 2'd1;
          case (hi)
            `C8DEC_HI_RMW_DIR: d_ea = {8'h00, byte1};
            `C8DEC_HI_RMW_IX1: d_ea = {8'h00, byte1} + {8'h00, idx};
            `C8DEC_HI_RMW_IX0: d_ea = {8'h00, idx};
            default:           d_ea = 16'h0000;
          endcase
          case (hi)
            `C8DEC_HI_RMW_DIR: d_cyc = (lo == `C8DEC_LO_TEST) ? 4'h4 : 4'h5; // RULE11
            `C8DEC_HI_RMW_IX0: d_cyc = (lo == `C8DEC_LO_TEST) ? 4'h4 : 4'h5; // RULE12
            `C8DEC_HI_RMW_IX1: d_cyc = (lo == `C8DEC_LO_TEST) ? 4'h5 : 4'h6; // RULE11
            default:           d_cyc = 4'h2; // RULE12
          endcase
          d_wr = d_has_ea && (lo != `C8DEC_LO_TEST); // RULE6
          if (lo == `C8DEC_LO_ZERO) begin
            d_res  = 8'h00; // RULE13
            d_resv = 1'b1;
            d_cc[`C8DEC_CC_N] = 1'b0; // RULE13
            d_cc[`C8DEC_CC_Z] = 1'b1;
          end else if (lo == `C8DEC_LO_TEST) begin
            d_cc = nz(ccr, (hi == `C8DEC_HI_RMW_ACC) ? acc :
                           (hi == `C8DEC_HI_RMW_IDX) ? idx : mem_data); // RULE6
          end
        end
      end
      4'h8: begin
        case (lo)
          4'h0: begin
            d_cyc = 4'h8; // RULE18
            d_cc  = mem_data[4:0]; // RULE18
          end
          4'h1: d_cyc = 4'h5; // RULE18
          4'h3: begin
            d_cyc = 4'hA; // RULE18
            d_cc[`C8DEC_CC_I] = 1'b1;
          end
          4'hD: begin
            d_cyc  = 4'h2; // RULE20
            d_res  = daa_v[7:0];
            d_resv = 1'b1;
            d_cc   = nz(ccr, daa_v[7:0]);
            d_cc[`C8DEC_CC_C] = daa_v[8] | ccr[`C8DEC_CC_C]; // RULE20
          end
          4'hE, 4'hF: d_cyc = 4'h4; // RULE21
          default: d_def = 1'b0; // RULE24
        endcase
      end
      4'h9: begin
        case (lo)
          4'h7: begin
            d_cyc  = 4'h2; // RULE17
            d_res  = acc;
            d_resv = 1'b1;
          end
          4'hF: begin
            d_cyc  = 4'h2; // RULE17
            d_res  = idx;
            d_resv = 1'b1;
          end
          4'h8: d_cc[`C8DEC_CC_C] = 1'b0; // RULE17
          4'h9: d_cc[`C8DEC_CC_C] = 1'b1; // RULE17
          4'hA: begin
            d_cyc = 4'h2;
            d_cc[`C8DEC_CC_I] = 1'b0; // RULE17
          end
          4'hB: begin
            d_cyc = 4'h2;
            d_cc[`C8DEC_CC_I] = 1'b1; // RULE17
          end
          4'hC: begin
            d_cyc  = 4'h2; // RULE19
            d_res  = `C8DEC_SP_RESET;
            d_resv = 1'b1;
          end
          4'hD: d_cyc = 4'h1; // RULE19
          default: d_def = 1'b0; // RULE24
        endcase
      end
      default: begin
        if (hi == `C8DEC_HI_IMM && lo == `C8DEC_LO_CALL) begin
          d_len  = 2'd2;
          d_cyc  = 4'h5; // RULE14
          d_jump = 1'b1;
          d_take = 1'b1;
          d_tgt  = pc + 16'h0002 + sext(byte1); // RULE22
        end else if (hi == `C8DEC_HI_IMM &&
                     (lo == `C8DEC_LO_STACC || lo == `C8DEC_LO_STIDX ||
                      lo == `C8DEC_LO_JUMP)) begin
          d_def = 1'b0; // RULE9
        end else begin
          d_has_ea = 1'b1;
          case (hi) // RULE7
            `C8DEC_HI_IMM: begin
              d_len = 2'd2;
              d_ea  = pc + 16'h0001;
            end
            `C8DEC_HI_DIR: begin
              d_len = 2'd2;
              d_ea  = {8'h00, byte1};
            end
            `C8DEC_HI_EXT: begin
              d_len = 2'd3;
              d_ea  = {byte1, byte2};
            end
            `C8DEC_HI_IX2: begin
              d_len = 2'd3; // RULE1
              d_ea  = {byte1, byte2} + {8'h00, idx}; // RULE1
            end
            `C8DEC_HI_IX1: begin
              d_len = 2'd2;
              d_ea  = {8'h00, byte1} + {8'h00, idx};
            end
            default: begin
              d_len = 2'd1;
              d_ea  = {8'h00, idx};
            end
          endcase
          case (lo)
            `C8DEC_LO_JUMP: begin
              d_cyc  = rm_cycles(hi, 2'd2); // RULE10
              d_jump = 1'b1;
              d_tgt  = d_ea;
            end
            `C8DEC_LO_CALL: begin
              d_cyc  = rm_cycles(hi, 2'd3); // RULE10
              d_jump = 1'b1;
              d_tgt  = d_ea;
            end
            `C8DEC_LO_STACC, `C8DEC_LO_STIDX: begin
              d_cyc  = rm_cycles(hi, 2'd1); // RULE9
              d_wr   = 1'b1;
              d_res  = (lo == `C8DEC_LO_STACC) ? acc : idx;
              d_resv = 1'b1;
              d_cc   = nz(ccr, d_res);
            end
            default: begin
              d_cyc = rm_cycles(hi, 2'd0); // RULE8
              if (lo == `C8DEC_LO_LDACC || lo == `C8DEC_LO_LDIDX) begin
                d_res  = mem_data;
                d_resv = 1'b1;
                d_cc   = nz(ccr, mem_data);
              end else if (lo == `C8DEC_LO_ADD || lo == `C8DEC_LO_ADC) begin
                d_res  = sum[7:0];
                d_resv = 1'b1;
                d_cc   = nz(ccr, sum[7:0]);
                d_cc[`C8DEC_CC_H] = half[4]; // RULE23
                d_cc[`C8DEC_CC_C] = sum[8];
              end
            end
          endcase
        end
      end
    endcase
    if (!d_def) begin
      d_len    = 2'd1; // RULE24
      d_cyc    = 4'h1;
      d_has_ea = 1'b0;
      d_wr     = 1'b0;
      d_jump   = 1'b0;
      d_take   = 1'b0;
      d_resv   = 1'b0;
      d_cc     = ccr;
    end
    d_npc = d_jump ? d_tgt : pc + {14'h0000, d_len}; // RULE5
  end

  always @* begin
    case (wb_adr_i)
      `C8DEC_ADR_OPCODE:  next_dat = {24'h000000, opcode};
      `C8DEC_ADR_OPERAND: next_dat = {8'h00, mem_data, byte2, byte1};
      `C8DEC_ADR_STATE:   next_dat = {11'h000, ccr, idx, acc};
      `C8DEC_ADR_PC:      next_dat = {16'h0000, pc};
      `C8DEC_ADR_DECODE:  next_dat = snap_decode;
      `C8DEC_ADR_EA:      next_dat = {16'h0000, snap_ea};
      `C8DEC_ADR_NEXTPC:  next_dat = {16'h0000, snap_npc};
      `C8DEC_ADR_RESULT:  next_dat = snap_result;
      default:            next_dat = 32'h00000000;
    endcase
  end

  always @(posedge clk_i) begin
    irq_meta <= irq_pin_i;
    irq_sync <= irq_meta;
    if (rst_i) begin
      wb_ack_o    <= 1'b0;
      wb_dat_o    <= 32'h00000000;
      opcode      <= `C8DEC_RST_OPCODE;
      byte1       <= `C8DEC_RST_BYTE;
      byte2       <= `C8DEC_RST_BYTE;
      mem_data    <= `C8DEC_RST_BYTE;
      acc         <= `C8DEC_RST_BYTE;
      idx         <= `C8DEC_RST_BYTE;
      ccr         <= `C8DEC_RST_CC;
      pc          <= `C8DEC_RST_PC;
      snap_decode <= 32'h00000000;
      snap_ea     <= 16'h0000;
      snap_npc    <= 16'h0000;
      snap_result <= 32'h00000000;
    end else begin
      wb_ack_o    <= bus_go;
      wb_dat_o    <= bus_go ? next_dat : 32'h00000000;
      snap_decode <= {16'h0000, 4'h0, d_take, d_wr, d_has_ea, d_def,
                      d_cyc, 2'b00, d_len};
      snap_ea     <= d_ea;
      snap_npc    <= d_npc;
      snap_result <= {18'h00000, d_resv, d_cc, d_res};
      if (bus_go && wb_we_i) begin
        case (wb_adr_i)
          `C8DEC_ADR_OPCODE: opcode <= merge8(opcode, wb_dat_i[7:0], wb_sel_i[0]);
          `C8DEC_ADR_OPERAND: begin
            byte1    <= merge8(byte1, wb_dat_i[7:0], wb_sel_i[0]);
            byte2    <= merge8(byte2, wb_dat_i[15:8], wb_sel_i[1]);
            mem_data <= merge8(mem_data, wb_dat_i[23:16], wb_sel_i[2]);
          end
          `C8DEC_ADR_STATE: begin
            acc <= merge8(acc, wb_dat_i[7:0], wb_sel_i[0]);
            idx <= merge8(idx, wb_dat_i[15:8], wb_sel_i[1]);
            if (wb_sel_i[2]) begin
              ccr <= wb_dat_i[20:16];
            end
          end
          `C8DEC_ADR_PC: begin
            pc[7:0]  <= merge8(pc[7:0], wb_dat_i[7:0], wb_sel_i[0]);
            pc[15:8] <= merge8(pc[15:8], wb_dat_i[15:8], wb_sel_i[1]);
          end
          default: ;
        endcase
      end
    end
  end

endmodule

// File: tb/c8dec_code_mem.sv
/*
  Program memory and interrupt line that stand beside the decoder.
  Assumes the bench fills the bytes and chooses the line level.
*/
module c8dec_code_mem (
  // Fetch address and wanted line level
  input  wire logic [7:0] adr_i,
  input  wire logic       irq_lvl_i,
  // The two bytes after the opcode, and the pin
  output logic [7:0]      b1_o,
  output logic [7:0]      b2_o,
  output logic            irq_pin_o
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] mem [0:255];
  assign b1_o = mem[adr_i + 8'h01];
  assign b2_o = mem[adr_i + 8'h02];
  // The pin moves off the clock grid, as a real line would.
  initial irq_pin_o = 1'b0;
  always @(irq_lvl_i) irq_pin_o <= #1.3 irq_lvl_i;
endmodule

// File: tb/c8dec_props.sv
/*
  Checker for the decoder: bus handshake and decode readback fields.
  Assumes it is bound to c8dec_top and sees only that module's ports.
*/
module c8dec_props (
  // Clock and reset
  input wire logic        clk_i,
  input wire logic        rst_i,
  // Register bus
  input wire logic [7:0]  wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0]  wb_sel_i,
  input wire logic        wb_we_i,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  // Interrupt pin
  input wire logic        irq_pin_i
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic [7:0] op;
  logic       dec_rd;
  wire        take    = wb_cyc_i && wb_stb_i && !wb_ack_o;
  wire        dec_ack = wb_ack_o && dec_rd;
  // A shadow of the opcode lets each decode answer be judged on its own.
  always @(posedge clk_i) begin
    if (rst_i) begin
      op     <= 8'h9D;
      dec_rd <= 1'b0;
    end else begin
      if (take && wb_we_i && wb_sel_i[0] && wb_adr_i == 8'h00) begin
        op <= wb_dat_i[7:0];
      end
      dec_rd <= take && !wb_we_i && wb_adr_i == 8'h10;
    end
  end
  sequence s_take;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence s_answer;
    wb_ack_o ##1 !wb_ack_o;
  endsequence
  a_ack_next_cycle: assert property (s_take |=> s_answer)
    else $error("ack did not pulse one cycle after a request");
  a_ack_has_cause: assert property ($rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without a request");
  a_data_quiet: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
    else $error("read data outside an ack");
  a_implied_short: assert property (dec_ack && op[7:4] inside {4'h4, 4'h5, 4'h8, 4'h9}
    |-> wb_dat_o[1:0] == 2'h1 && !wb_dat_o[9])
    else $error("implied opcode not one byte without address");
  a_branch_shape: assert property (dec_ack && op[7:4] == 4'h2
    |-> wb_dat_o[1:0] == 2'h2 && wb_dat_o[7:4] == 4'h3)
    else $error("relative branch length or cycles wrong");
  a_bit_jump_shape: assert property (dec_ack && op[7:4] == 4'h0
    |-> wb_dat_o[1:0] == 2'h3 && wb_dat_o[7:4] == 4'h5)
    else $error("bit test jump length or cycles wrong");
  a_bit_write_shape: assert property (dec_ack && op[7:4] == 4'h1
    |-> wb_dat_o[1:0] == 2'h2 && wb_dat_o[7:4] == 4'h5 && wb_dat_o[10])
    else $error("page zero bit write decoded wrong");
  a_wide_index_len: assert property (dec_ack && op[7:4] == 4'hD |-> wb_dat_o[1:0] == 2'h3)
    else $error("sixteen bit offset not three bytes");
  a_trap_cycles: assert property (dec_ack && op == 8'h83 |-> wb_dat_o[7:4] == 4'hA)
    else $error("trap cycle count wrong");
endmodule

bind c8dec_top c8dec_props i_c8dec_props (
  .clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i),
  .wb_sel_i(wb_sel_i), .wb_we_i(wb_we_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .irq_pin_i(irq_pin_i)
);

// File: tb/c8dec_tb_top.sv
/*
  Self-checking bench: every opcode is decoded against a model.
  Assumes one 4 ns clock and a synchronous active-high reset.
*/
module c8dec_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [15:0] RMW_OK = 16'hB7D9;
  localparam logic [15:0] CTL8 = 16'hE00B;
  localparam logic [15:0] CTL9 = 16'hBF80;
  localparam logic [15:0] IMM_OK = 16'h6F7F;
  localparam int LENS [16] = '{3, 2, 2, 2, 1, 1, 2, 1, 1, 1, 2, 2, 3, 3, 2, 1};
  localparam int CYC [4][5] = '{'{3, 4, 5, 4, 3}, '{3, 4, 5, 4, 4}, '{2, 3, 4, 3, 2},
                               '{5, 6, 6, 5, 5}};
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic [7:0]  wb_adr_i = 8'h00;
  logic [31:0] wb_dat_i = 32'h0;
  logic [3:0]  wb_sel_i = 4'h0;
  logic        wb_we_i = 1'b0;
  logic        wb_cyc_i = 1'b0;
  logic        wb_stb_i = 1'b0;
  logic [31:0] wb_dat_o;
  logic        wb_ack_o;
  logic        irq_pin_i;
  logic        irq_lvl = 1'b0;
  logic [7:0]  pc_lo = 8'h00;
  logic [7:0]  b1;
  logic [7:0]  b2;
  logic [7:0]  rnd = 8'h17;
  int          miscompares = 0;
  int          samples_checked = 0;
  always #2 clk_i = ~clk_i;
  c8dec_top i_c8dec_top (
    .clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i),
    .wb_sel_i(wb_sel_i), .wb_we_i(wb_we_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .irq_pin_i(irq_pin_i)
  );
  c8dec_code_mem i_c8dec_code_mem (
    .adr_i(pc_lo), .irq_lvl_i(irq_lvl), .b1_o(b1), .b2_o(b2), .irq_pin_o(irq_pin_i)
  );
  function automatic logic [7:0] nxt(input logic [7:0] l);
    return {l[6:0], l[7] ^ l[5] ^ l[4] ^ l[3]};
  endfunction
  // No count of wait states is assumed; only the watchdog ends a wait.
  task automatic wb_xfer(input logic [7:0] a, input logic we, input logic [31:0] d,
                         output logic [31:0] q);
    wb_adr_i <= a;
    wb_we_i <= we;
    wb_dat_i <= d;
    wb_sel_i <= 4'hF;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    @(posedge clk_i);
    while (wb_ack_o !== 1'b1) begin
      @(posedge clk_i);
    end
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_adr(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic trial(input logic [7:0] op);
    logic [31:0] q;
    logic [15:0] pc, ea, npc, tgt;
    logic [7:0]  acc, idx, m, cv;
    logic [4:0]  f, ef;
    logic [3:0]  hi, lo;
    logic        tk, def, wr, hasea, dc;
    int          len, cyc, dv;
    hi = op[7:4];
    lo = op[3:0];
    rnd = nxt(rnd);
    pc_lo = rnd;
    irq_lvl = rnd[2];
    acc = nxt(rnd);
    idx = nxt(acc);
    m = nxt(idx);
    rnd = nxt(m);
    f = rnd[4:0];
    pc = {8'h10, pc_lo};
    wb_xfer(8'h0C, 1'b1, {16'h0, pc}, q);
    wb_xfer(8'h00, 1'b1, {24'h0, op}, q);
    wb_xfer(8'h08, 1'b1, {11'h0, f, idx, acc}, q);
    wb_xfer(8'h04, 1'b1, {8'h0, m, b2, b1}, q);
    cv = {!irq_lvl, !f[3], !f[2], !f[4], !f[1], !f[0], !(f[0] | f[1]), 1'b1};
    tk = (hi == 4'h2) ? cv[lo[3:1]] ^ lo[0] : (hi == 4'h0) ? m[lo[3:1]] ^ lo[0] : op == 8'hAD;
    tgt = pc + ((hi == 4'h0) ? 16'h3 + {{8{b2[7]}}, b2} : 16'h2 + {{8{b1[7]}}, b1});
    def = (hi inside {[4'h3:4'h7]}) ? RMW_OK[lo] : (hi == 4'h8) ? CTL8[lo] :
          (hi == 4'h9) ? CTL9[lo] : (hi == 4'hA) ? IMM_OK[lo] : 1'b1;
    ea = 16'h0;
    case (hi)
      4'h0, 4'h1, 4'h3, 4'hB: ea = {8'h0, b1};
      4'hC: ea = {b1, b2};
      4'hD: ea = {b1, b2} + idx;
      4'h6, 4'hE: ea = b1 + idx;
      4'h7, 4'hF: ea = {8'h0, idx};
      4'hA: ea = (lo == 4'hD) ? 16'h0 : pc + 16'h1;
      default: ea = 16'h0;
    endcase
    len = LENS[hi];
    case (hi)
      4'h0, 4'h1: cyc = 5;
      4'h2: cyc = 3;
      4'h3, 4'h7: cyc = 5 - (lo == 4'hD);
      4'h4, 4'h5: cyc = 2;
      4'h6: cyc = 6 - (lo == 4'hD);
      4'h8: cyc = (lo == 4'h0) ? 8 : (lo == 4'h1) ? 5 : (lo == 4'h3) ? 10 : (lo == 4'hD) ? 2 : 4;
      4'h9: cyc = (lo inside {4'h8, 4'h9, 4'hD}) ? 1 : 2;
      4'hA: cyc = (lo == 4'hD) ? 5 : 2;
      default: cyc = CYC[(lo == 4'hC) ? 2 : (lo == 4'hD) ? 3 :
                         (lo == 4'h7 || lo == 4'hF) ? 1 : 0][hi - 4'hB];
    endcase
    // Undefined codes act as a one-byte pause with no side effects.
    if (!def) begin
      len = 1;
      cyc = 1;
      ea = 16'h0;
      tk = 1'b0;
    end
    npc = tk ? tgt : (hi > 4'hA && lo inside {4'hC, 4'hD}) ? ea : pc + len[15:0];
    hasea = def && (hi inside {4'h0, 4'h1, 4'h3, 4'h6, 4'h7} || hi > 4'hA ||
                    (hi == 4'hA && lo != 4'hD));
    wr = def && (hi == 4'h1 || (hi inside {4'h3, 4'h6, 4'h7} && lo != 4'hD) ||
                 (hi > 4'hA && lo inside {4'h7, 4'hF}));
    ef = f;
    if (op == 8'h98 || op == 8'h99) ef[0] = op[0];
    if (op == 8'h9A || op == 8'h9B || op == 8'h83) ef[3] = op[0];
    if (op == 8'h80) ef = m[4:0];
    dv = acc + ((f[4] || acc[3:0] > 4'h9) ? 6 : 0);
    dc = f[0] || dv > 'h9F;
    dv = dv + (dc ? 'h60 : 0);
    cv = op[3] ? (op[0] ? idx : 8'hFF) : acc;
    wb_xfer(8'h10, 1'b0, 32'h0, q);
    chk_word({28'h0, q[11:8]}, {28'h0, tk, wr, hasea, def});
    chk_word({24'h0, q[7:0]}, {24'h0, cyc[3:0], 2'h0, len[1:0]});
    wb_xfer(8'h14, 1'b0, 32'h0, q);
    chk_adr(q[15:0], ea);
    wb_xfer(8'h18, 1'b0, 32'h0, q);
    chk_adr(q[15:0], npc);
    wb_xfer(8'h1C, 1'b0, 32'h0, q);
    if (hi == 4'h0) chk_word({31'h0, q[8]}, {31'h0, m[lo[3:1]]});
    if (hi == 4'h1) chk_word({24'h0, q[7:0]},
                             {24'h0, lo[0] ? m & ~(8'h1 << lo[3:1]) : m | (8'h1 << lo[3:1])});
    if (lo == 4'hF && hi inside {[4'h3:4'h7]}) chk_word({18'h0, q[13:0]},
                                                        {18'h0, 1'b1, f[4:3], 2'h1, f[0], 8'h00});
    if (op == 8'hBB) chk_word({31'h0, q[12]}, {31'h0, acc[3:0] + m[3:0] > 5'h0F});
    if (op == 8'h8D) chk_word({18'h0, q[13:0]},
                              {18'h0, 1'b1, f[4:3], dv[7], dv[7:0] == 8'h0, dc, dv[7:0]});
    if (!def || (op[7:5] == 3'b100 && op != 8'h8D))
      chk_word({27'h0, q[12:8]}, {27'h0, ef});
    if (op inside {8'h97, 8'h9C, 8'h9F})
      chk_word({23'h0, q[13], q[7:0]}, {23'h0, 1'b1, cv});
  endtask
  task automatic wrap_up;
    $display("Comparisons %0d, mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  initial begin
    logic [31:0] q;
    for (int i = 0; i < 256; i++) begin
      rnd = nxt(rnd);
      i_c8dec_code_mem.mem[i] = rnd;
    end
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    wb_xfer(8'h00, 1'b0, 32'h0, q);
    chk_word(q, 32'h9D);
    wb_xfer(8'h08, 1'b0, 32'h0, q);
    chk_word(q, 32'h0008_0000);
    wb_xfer(8'h20, 1'b1, 32'hFFFF_FFFF, q);
    wb_xfer(8'h20, 1'b0, 32'h0, q);
    chk_word(q, 32'h0);
    for (int i = 0; i < 256; i++) trial(i[7:0]);
    wrap_up;
  end
  // About four times the expected run length.
  initial begin
    #100us;
    miscompares++;
    wrap_up;
  end
endmodule
